// ### src/srs_pkg.sv
// package of constants for the suspend/resume sequencer
package srs_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TIMING = 8'h08;
   // ------------------------------------------------------------
   // control field positions and reset values
   // ------------------------------------------------------------
   localparam int CTRL_REFMODE_BIT = 0;
   localparam int CTRL_CPUOFF_BIT  = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ------------------------------------------------------------
   // status field positions
   // ------------------------------------------------------------
   localparam int ST_STATE_LSB     = 0;
   localparam int ST_SUSPENDED_BIT = 4;
   localparam int ST_REQ_BIT       = 5;
   localparam int ST_OVERTIME_BIT  = 6;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int ENTRY_MAX_US   = 1000;
   localparam int SLOT_RST_MIN_US = 2000;
   localparam int ENTRY_MAX_CYC  = ENTRY_MAX_US * CLK_MHZ;
   localparam int SLOT_RST_CYC   = SLOT_RST_MIN_US * CLK_MHZ;
   localparam int SYNC_STAGES    = 3;
   // ------------------------------------------------------------
   // sequencer states, gray along entry -> suspend -> resume
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SRS_RUN      = 3'b000,
      SRS_WAIT_REF = 3'b001,
      SRS_STOP     = 3'b011,
      SRS_SUSPEND  = 3'b010,
      SRS_RESTART  = 3'b110,
      SRS_RESET    = 3'b111
   } srs_state_t;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### src/srs_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module srs_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic clk_in,    // destination clock
   input  wire logic rst_in,    // async reset, active high
   input  wire logic async_in,  // level from another domain
   output logic      sync_out   // filtered level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   // first stage feeds only the second
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   // a change counts once stages two and three agree
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_out <= RESET_VAL;
      end else if (s2_ff == s3_ff) begin
         sync_out <= s3_ff;
      end
   end
endmodule

// ### src/srs_edge.sv
// rising-edge tick detector for the 32 kHz oscillator level
`timescale 1ns/1ps
module srs_edge (
   input  wire logic clk_in,   // system clock
   input  wire logic rst_in,   // async reset, active high
   input  wire logic lvl_in,   // synchronised level
   output logic      rise_out  // one-cycle pulse on rising edge
);
   logic last_ff;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         last_ff  <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         last_ff  <= lvl_in;
         rise_out <= lvl_in & ~last_ff;
      end
   end
endmodule

// ### src/srs_top.sv
// suspend/resume sequencer with AXI4-Lite control
// What this block does
// - suspend request low starts the transition into suspend
// - wait for the next refresh hold ack, then stop clocks and gate inputs
// - enable leakage control when suspend is entered
// - suspend refresh engine starts at once on suspend entry
// - suspend refresh uses CAS-before-RAS or self-refresh per control bit
// - cpu power-off bit clear keeps cpu powered and local bus held
// - cpu power-off bit set powers cpu side down with pull-downs
// - a wait for the hold ack of 1 ms less 4 cycles only sets the overtime status bit
// - state and registers are kept throughout suspend
// - request is sampled on 32 kHz; high restarts stopped clocks
// - on resume re-enable outputs and hold slot reset at least 2 ms
// - with cpu power-off set, also drive cpu and coprocessor resets
// - end of resume stops suspend refresh, normal refresh resumes
// - suspended: hold cpu and system clocks low, stop all but 32 kHz
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module srs_top
   import srs_pkg::*;
#(
   parameter int ENTRY_LIMIT = srs_pkg::ENTRY_MAX_CYC,
   parameter int SLOT_RESET  = srs_pkg::SLOT_RST_CYC
) (
   input  wire logic        mclk_in,            // 200 MHz system clock
   input  wire logic        rst_in,             // async reset, active high
   input  wire logic        suspend_req_n_in,   // suspend request, active low
   input  wire logic        osc32k_in,          // 32 kHz oscillator level
   input  wire logic        hold_ack_in,        // refresh hold acknowledge
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,       // write address
   input  wire logic        s_axi_awvalid,      // write address valid
   output logic             s_axi_awready,      // write address ready
   input  wire logic [31:0] s_axi_wdata,        // write data
   input  wire logic [3:0]  s_axi_wstrb,        // write strobes
   input  wire logic        s_axi_wvalid,       // write data valid
   output logic             s_axi_wready,       // write data ready
   output logic [1:0]       s_axi_bresp,        // write response
   output logic             s_axi_bvalid,       // write response valid
   input  wire logic        s_axi_bready,       // write response ready
   input  wire logic [7:0]  s_axi_araddr,       // read address
   input  wire logic        s_axi_arvalid,      // read address valid
   output logic             s_axi_arready,      // read address ready
   output logic [31:0]      s_axi_rdata,        // read data
   output logic [1:0]       s_axi_rresp,        // read response
   output logic             s_axi_rvalid,       // read data valid
   input  wire logic        s_axi_rready,       // read data ready
   // sequencer outputs
   output logic             clk_run_out,        // non-essential clocks enabled
   output logic             cpu_clk_gate_out,   // cpu double-rate clock enable
   output logic             sys_clk_gate_out,   // system clock output enable
   output logic             input_gate_out,     // control inputs forced inactive
   output logic             leakage_ctrl_out,   // leakage control enabled
   output logic             susp_refresh_out,   // suspend refresh engine running
   output logic             self_refresh_out,   // 1 self-refresh, 0 CAS-before-RAS
   output logic             normal_refresh_out, // normal 14.318 MHz refresh active
   output logic             cpu_hold_out,       // cpu local bus held
   output logic             cpu_power_off_out,  // cpu interface powered down
   output logic             pulldown_en_out,    // pull-downs on three-stated pins
   output logic             slot_reset_drive,   // slot bus reset
   output logic             cpu_reset_out,      // cpu reset
   output logic             coprocessor_reset_out, // coprocessor reset
   output logic             suspended_out       // fully in suspend
);
   // ------------------------------------------------------------
   // synchronisers and 32 kHz sampling
   // ------------------------------------------------------------
   logic osc_lvl;
   logic osc_tick;
   logic req_lvl;
   logic req_smp_ff;
   logic req_smp2_ff;

   srs_sync #(.RESET_VAL(1'b0)) u_osc_sync (
      .clk_in   (mclk_in),
      .rst_in   (rst_in),
      .async_in (osc32k_in),
      .sync_out (osc_lvl)
   );
   srs_sync #(.RESET_VAL(1'b1)) u_req_sync (
      .clk_in   (mclk_in),
      .rst_in   (rst_in),
      .async_in (suspend_req_n_in),
      .sync_out (req_lvl)
   );
   srs_edge u_osc_edge (
      .clk_in   (mclk_in),
      .rst_in   (rst_in),
      .lvl_in   (osc_lvl),
      .rise_out (osc_tick)
   );

   // two 32k samples
   // the request is re-sampled on 32 kHz ticks so both edges see the slow clock
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         req_smp_ff  <= 1'b1;
         req_smp2_ff <= 1'b1;
      end else if (osc_tick) begin
         req_smp_ff  <= req_lvl;
         req_smp2_ff <= req_smp_ff;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic        refmode_ff;
   logic        cpuoff_ff;
   logic        overtime_ff;
   logic        wr_go;
   logic        rd_go;
   logic [7:0]  aw_ff;
   logic        aw_hold_ff;
   logic [31:0] w_ff;
   logic [3:0]  ws_ff;
   logic        w_hold_ff;
   srs_state_t  state_ff;
   srs_state_t  nxt_state;
   logic [31:0] cnt_ff;

   // ------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------
   assign wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_hold_ff    <= 1'b0;
         w_hold_ff     <= 1'b0;
         aw_ff         <= 8'h00;
         w_ff          <= 32'h0000_0000;
         ws_ff         <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff         <= s_axi_awaddr;
            aw_hold_ff    <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff         <= s_axi_wdata;
            ws_ff        <= s_axi_wstrb;
            w_hold_ff    <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_ff   <= 1'b0;
            w_hold_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_ff == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // registers kept
   // control bits change only on reset or a strobed write to ADDR_CTRL, so suspend keeps them
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         refmode_ff <= CTRL_RESET[CTRL_REFMODE_BIT];
         cpuoff_ff  <= CTRL_RESET[CTRL_CPUOFF_BIT];
      end else if (wr_go && aw_ff == ADDR_CTRL && ws_ff[0]) begin
         refmode_ff <= w_ff[CTRL_REFMODE_BIT];
         cpuoff_ff  <= w_ff[CTRL_CPUOFF_BIT];
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------
   assign rd_go = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         case (s_axi_araddr)
            ADDR_CTRL: begin
               s_axi_rdata[CTRL_REFMODE_BIT] <= refmode_ff;
               s_axi_rdata[CTRL_CPUOFF_BIT]  <= cpuoff_ff;
            end
            ADDR_STATUS: begin
               s_axi_rdata[ST_STATE_LSB +: 3]  <= state_ff;
               s_axi_rdata[ST_SUSPENDED_BIT]   <= suspended_out;
               s_axi_rdata[ST_REQ_BIT]         <= req_smp2_ff;
               s_axi_rdata[ST_OVERTIME_BIT]    <= overtime_ff;
            end
            ADDR_TIMING: begin
               s_axi_rdata <= cnt_ff;
            end
            default: begin
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SRS_RUN:      if (!req_smp2_ff) nxt_state = SRS_WAIT_REF;
         SRS_WAIT_REF: if (hold_ack_in) nxt_state = SRS_STOP;
         SRS_STOP:     nxt_state = SRS_SUSPEND;
         SRS_SUSPEND:  if (req_smp2_ff) nxt_state = SRS_RESTART;
         SRS_RESTART:  nxt_state = SRS_RESET;
         SRS_RESET:    if (cnt_ff >= 32'(SLOT_RESET - 1)) nxt_state = SRS_RUN;
         default:      nxt_state = SRS_RUN;
      endcase
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= SRS_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // one counter times both entry and reset; cleared on every state change
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= 32'h0000_0000;
      end else if (nxt_state != state_ff) begin
         cnt_ff <= 32'h0000_0000;
      end else if (cnt_ff != 32'hFFFF_FFFF) begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
      end
   end

   // entry bound
   // a late entry is only flagged; the hold ack must still come to finish it
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         overtime_ff <= 1'b0;
      end else if (state_ff == SRS_WAIT_REF && cnt_ff >= 32'(ENTRY_LIMIT - 4)) begin
         overtime_ff <= 1'b1;
      end else if (state_ff == SRS_RUN && !req_smp2_ff) begin
         overtime_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic in_susp;
   logic in_reset;
   assign in_susp  = (state_ff == SRS_STOP) || (state_ff == SRS_SUSPEND);
   assign in_reset = (state_ff == SRS_RESTART) || (state_ff == SRS_RESET);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_run_out      <= 1'b1;
         cpu_clk_gate_out <= 1'b1;
         sys_clk_gate_out <= 1'b1;
         input_gate_out   <= 1'b0;
      end else begin
         clk_run_out      <= ~in_susp;
         cpu_clk_gate_out <= ~in_susp;
         sys_clk_gate_out <= ~in_susp;
         input_gate_out   <= in_susp;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         leakage_ctrl_out   <= 1'b0;
         susp_refresh_out   <= 1'b0;
         self_refresh_out   <= 1'b0;
         normal_refresh_out <= 1'b1;
         suspended_out      <= 1'b0;
      end else begin
         leakage_ctrl_out   <= in_susp;
         susp_refresh_out   <= in_susp | in_reset;
         self_refresh_out   <= refmode_ff;
         normal_refresh_out <= ~(in_susp | in_reset);
         suspended_out      <= (state_ff == SRS_SUSPEND);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_hold_out      <= 1'b0;
         cpu_power_off_out <= 1'b0;
         pulldown_en_out   <= 1'b0;
      end else begin
         cpu_hold_out      <= in_susp & ~cpuoff_ff;
         cpu_power_off_out <= in_susp & cpuoff_ff;
         pulldown_en_out   <= in_susp & cpuoff_ff;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         slot_reset_drive      <= 1'b0;
         cpu_reset_out         <= 1'b0;
         coprocessor_reset_out <= 1'b0;
      end else begin
         slot_reset_drive      <= in_reset;
         cpu_reset_out         <= in_reset & cpuoff_ff;
         coprocessor_reset_out <= in_reset & cpuoff_ff;
      end
   end
endmodule

// ### tb/srs_monitor.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
module srs_monitor #(
   parameter int SLOT_RESET = 100
) (
   input wire logic mclk_in,               // clock
   input wire logic rst_in,                // reset
   input wire logic hold_ack_in,           // hold ack
   input wire logic clk_run_out,           // clocks run
   input wire logic cpu_clk_gate_out,      // cpu clock
   input wire logic sys_clk_gate_out,      // system clock
   input wire logic input_gate_out,        // input gate
   input wire logic leakage_ctrl_out,      // leakage
   input wire logic susp_refresh_out,      // slow refresh
   input wire logic normal_refresh_out,    // normal refresh
   input wire logic cpu_hold_out,          // cpu held
   input wire logic cpu_power_off_out,     // cpu off
   input wire logic pulldown_en_out,       // pull-downs
   input wire logic slot_reset_drive,      // slot reset
   input wire logic cpu_reset_out,         // cpu reset
   input wire logic coprocessor_reset_out, // copro reset
   input wire logic suspended_out          // suspended
);
   int unsigned slot_cnt_ff;
   default clocking dc @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   // length of the current slot reset pulse
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         slot_cnt_ff <= 0;
      end else begin
         slot_cnt_ff <= slot_reset_drive ? slot_cnt_ff + 1 : 0;
      end
   end
   sequence s_stop_phase;
      leakage_ctrl_out && !clk_run_out && !suspended_out;
   endsequence
   sequence s_held;
      suspended_out && input_gate_out && leakage_ctrl_out;
   endsequence
   AST_CLK_STOP: assert property (suspended_out |-> !clk_run_out && !cpu_clk_gate_out
      && !sys_clk_gate_out) else $error("clocks run in suspend");
   AST_HELD: assert property (suspended_out |-> s_held)
      else $error("inputs or leakage not held");
   AST_SUSP_REFRESH: assert property (suspended_out |-> susp_refresh_out)
      else $error("no slow refresh in suspend");
   AST_ONE_REFRESH: assert property (normal_refresh_out != susp_refresh_out)
      else $error("refresh sources overlap");
   AST_CPU_OPTION: assert property (suspended_out |-> cpu_hold_out != cpu_power_off_out
      && pulldown_en_out == cpu_power_off_out) else $error("cpu option mismatch");
   AST_ENTRY: assert property ($rose(leakage_ctrl_out) |->
      ($past(hold_ack_in, 2) and s_stop_phase) ##1 s_held) else $error("entry order wrong");
   AST_RESUME: assert property ($fell(suspended_out) |-> slot_reset_drive && clk_run_out
      && cpu_clk_gate_out && sys_clk_gate_out) else $error("resume did not restart");
   AST_SLOT_LEN: assert property ($fell(slot_reset_drive) |-> slot_cnt_ff >= SLOT_RESET)
      else $error("slot reset too short");
   AST_CPU_RESET: assert property (cpu_reset_out == coprocessor_reset_out
      && (!cpu_reset_out || slot_reset_drive)) else $error("cpu resets mismatch");
   AST_REFRESH_BACK: assert property ($fell(slot_reset_drive) |-> normal_refresh_out)
      else $error("normal refresh not back");
endmodule

bind srs_top srs_monitor #(.SLOT_RESET(SLOT_RESET)) u_mon (
   .mclk_in, .rst_in, .hold_ack_in, .clk_run_out, .cpu_clk_gate_out, .sys_clk_gate_out,
   .input_gate_out, .leakage_ctrl_out, .susp_refresh_out, .normal_refresh_out, .cpu_hold_out,
   .cpu_power_off_out, .pulldown_en_out, .slot_reset_drive, .cpu_reset_out,
   .coprocessor_reset_out, .suspended_out);

// ### tb/srs_pmu_model.sv
// power unit model: slow oscillator and suspend request
`timescale 1ns/1ps
module srs_pmu_model #(
   parameter int OSC_HALF_NS = 93,
   parameter int MIN_DWELL   = 40
) (
   input  wire logic mclk_in,           // system clock
   input  wire logic sleep_cmd_in,      // 1 asks for suspend
   input  wire logic glitch_in,         // brief noise on request
   output logic      suspend_req_n_out, // suspend request, active low
   output logic      osc32k_out         // slow oscillator
);
   logic req_n_ff = 1'h1;
   int   dwell_ff = 0;
   initial osc32k_out = 1'h0;
   // power to the device is never cut here, so it keeps refresh
   always #(OSC_HALF_NS) osc32k_out = ~osc32k_out;
   always_ff @(posedge mclk_in) begin
      if (sleep_cmd_in) begin
         req_n_ff <= 1'h0;
      end else if (dwell_ff >= MIN_DWELL) begin
         req_n_ff <= 1'h1;
      end
      dwell_ff <= req_n_ff ? 0 : dwell_ff + 1;
   end
   // noise only ever pulls the line low, as a real glitch would
   assign suspend_req_n_out = req_n_ff & ~glitch_in;
endmodule

// ### tb/tb_suspend_resume_sequencer.sv
// self-checking bench for the suspend/resume sequencer
`timescale 1ns/1ps
module tb_suspend_resume_sequencer;
   import srs_pkg::*;
   localparam int ENTRY_LIM = 64;
   localparam int SLOT_RST  = 100;
   logic        mclk_in = 1'h0, rst_in = 1'h1, hold_ack_in = 1'h0;
   logic        suspend_req_n_in, osc32k_in, sleep_cmd = 1'h0, glitch = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        clk_run_out, cpu_clk_gate_out, sys_clk_gate_out, input_gate_out;
   logic        leakage_ctrl_out, susp_refresh_out, self_refresh_out, normal_refresh_out;
   logic        cpu_hold_out, cpu_power_off_out, pulldown_en_out, slot_reset_drive;
   logic        cpu_reset_out, coprocessor_reset_out, suspended_out;
   int          err_count = 0, n_checks = 0;
   always #2.5 mclk_in = ~mclk_in;
   srs_top #(.ENTRY_LIMIT(ENTRY_LIM), .SLOT_RESET(SLOT_RST)) dut (
      .mclk_in, .rst_in, .suspend_req_n_in, .osc32k_in, .hold_ack_in, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .clk_run_out, .cpu_clk_gate_out, .sys_clk_gate_out, .input_gate_out,
      .leakage_ctrl_out, .susp_refresh_out, .self_refresh_out, .normal_refresh_out,
      .cpu_hold_out, .cpu_power_off_out, .pulldown_en_out, .slot_reset_drive,
      .cpu_reset_out, .coprocessor_reset_out, .suspended_out);
   srs_pmu_model #(.OSC_HALF_NS(93), .MIN_DWELL(40)) pmu (
      .mclk_in, .sleep_cmd_in(sleep_cmd), .glitch_in(glitch),
      .suspend_req_n_out(suspend_req_n_in), .osc32k_out(osc32k_in));
   task automatic chk_bit(input string name, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", name, e, g);
      end
   endtask
   task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      @(posedge mclk_in);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      fork
         begin
            do @(posedge mclk_in); while (s_axi_awready !== 1'h1);
            s_axi_awvalid <= 1'h0;
         end
         begin
            do @(posedge mclk_in); while (s_axi_wready !== 1'h1);
            s_axi_wvalid <= 1'h0;
         end
      join
      do @(posedge mclk_in); while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_in);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do @(posedge mclk_in); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge mclk_in); while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ADDR_CTRL, d, r);
      chk_word("ctrl_reset", CTRL_RESET, d);
      axi_rd(ADDR_STATUS, d, r);
      chk_word("status_reset", 32'h1 << ST_REQ_BIT, d);
      axi_wr(ADDR_CTRL, 32'h0000_0041, 4'hF, r);
      axi_wr(ADDR_CTRL, 32'h0000_0000, 4'h0, r);
      axi_rd(ADDR_CTRL, d, r);
      chk_word("ctrl_strobe", 32'h0000_0041, d);
      axi_wr(ADDR_STATUS, 32'h0000_00FF, 4'hF, r);
      chk_word("status_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_rd(8'h0C, d, r);
      chk_word("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk_word("unmapped_data", 32'h0, d);
      $display("test registers done");
   endtask
   task automatic t_glitch();
      logic [31:0] d;
      logic [1:0]  r;
      // noise that falls between two slow ticks is never sampled
      @(posedge osc32k_in);
      repeat (10) @(posedge mclk_in);
      glitch      <= 1'h1;
      hold_ack_in <= 1'h1;
      repeat (10) @(posedge mclk_in);
      glitch      <= 1'h0;
      hold_ack_in <= 1'h0;
      repeat (120) @(posedge mclk_in);
      axi_rd(ADDR_STATUS, d, r);
      chk_word("glitch_state", 32'h1 << ST_REQ_BIT, d);
      chk_bit("glitch_clk", 1'h1, clk_run_out);
      $display("test glitch done");
   endtask
   task automatic t_suspend(input logic [31:0] ctrl, input int dly);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      axi_wr(ADDR_CTRL, ctrl, 4'hF, r);
      @(posedge mclk_in);
      sleep_cmd <= 1'h1;
      d = 32'h0;
      for (n = 0; n < 100 && d[2:0] !== 3'h1; n++)
         axi_rd(ADDR_STATUS, d, r);
      chk_word("wait_state", 32'h1, {29'h0, d[2:0]});
      chk_bit("req_low", 1'h0, d[ST_REQ_BIT]);
      chk_bit("clk_before_ack", 1'h1, clk_run_out);
      repeat (dly) @(posedge mclk_in);
      axi_rd(ADDR_STATUS, d, r);
      chk_bit("overtime", (dly > ENTRY_LIM) ? 1'h1 : 1'h0, d[ST_OVERTIME_BIT]);
      @(posedge mclk_in);
      hold_ack_in <= 1'h1;
      @(posedge mclk_in);
      hold_ack_in <= 1'h0;
      for (n = 0; n < 20 && suspended_out !== 1'h1; n++)
         @(posedge mclk_in);
      chk_bit("suspended", 1'h1, suspended_out);
      chk_bit("clk_gate", 1'h0, cpu_clk_gate_out | sys_clk_gate_out | clk_run_out);
      chk_bit("in_gate", 1'h1, input_gate_out & leakage_ctrl_out);
      chk_bit("susp_refresh", 1'h1, susp_refresh_out & ~normal_refresh_out);
      chk_bit("self_refresh", ctrl[CTRL_REFMODE_BIT], self_refresh_out);
      chk_bit("cpu_hold", ~ctrl[CTRL_CPUOFF_BIT], cpu_hold_out);
      chk_bit("cpu_off", ctrl[CTRL_CPUOFF_BIT], cpu_power_off_out & pulldown_en_out);
      axi_rd(ADDR_CTRL, d, r);
      chk_word("ctrl_kept", ctrl, d);
      @(posedge mclk_in);
      sleep_cmd <= 1'h0;
      for (n = 0; n < 400 && slot_reset_drive !== 1'h1; n++)
         @(posedge mclk_in);
      chk_bit("slot_reset", 1'h1, slot_reset_drive);
      chk_bit("clk_restart", 1'h1, clk_run_out & cpu_clk_gate_out & sys_clk_gate_out);
      chk_bit("cpu_reset", ctrl[CTRL_CPUOFF_BIT], cpu_reset_out & coprocessor_reset_out);
      for (n = 0; n < 1000 && slot_reset_drive === 1'h1; n++)
         @(posedge mclk_in);
      chk_bit("slot_len", 1'h1, (n >= SLOT_RST) ? 1'h1 : 1'h0);
      chk_bit("normal_refresh", 1'h1, normal_refresh_out & ~susp_refresh_out);
      $display("test suspend ctrl %h delay %0d done", ctrl, dly);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // runs take under ten microseconds; this leaves wide margin
   initial begin
      #200us;
      err_count++;
      $display("ERROR watchdog expected done seen hang");
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'h0;
      t_regs();
      t_glitch();
      t_suspend(32'h0000_0000, 0);
      t_suspend(32'h0000_0001, 200);
      t_suspend(32'h0000_0040, 0);
      t_suspend(32'h0000_0041, 0);
      print_verdict();
   end
endmodule
